// [qpd_pkg.sv]
// Package: command codes, field positions and reset values for the decoder
package qpd_pkg;

  // Channel count of the quad device
  localparam int NUM_CH = 4;

  // Command codes in bits 15:12 of a command word
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;  // Serial data to wiper
  localparam logic [3:0] CMD_WR_INPUT = 4'h2;  // Serial data to input reg
  localparam logic [3:0] CMD_READ     = 4'h3;  // Readback
  localparam logic [3:0] CMD_COPY_IN  = 4'h6;  // Input register to wiper
  localparam logic [3:0] CMD_NVM_XFER = 4'h7;  // Wiper <-> stored value
  localparam logic [3:0] CMD_WR_NVM   = 4'h8;  // Serial data to stored
  localparam logic [3:0] CMD_SCALE    = 4'h9;  // Enter or leave top scale
  localparam logic [3:0] CMD_SW_RESET = 4'hB;  // Reload wipers from stored
  localparam logic [3:0] CMD_CTRL     = 4'hD;  // Load control register

  // Field positions inside a command word
  localparam int OPC_MSB  = 15;
  localparam int OPC_LSB  = 12;
  localparam int ADDR_BCAST_BIT = 11;  // broadcast_address_bit
  localparam int ADDR_RES_BIT   = 10;  // resistor_select_address_bit
  localparam int ADDR_CH_MSB    = 9;   // channel_select_high_bit
  localparam int ADDR_CH_LSB    = 8;   // channel_select_low_bit
  localparam int SCALE_TOP_BIT  = 7;   // Scale command acts only when set; data bit 0 then sets or clears top scale
  localparam int XFER_DIR_BIT   = 0;   // 1: wiper to stored, 0: reverse

  // Control register layout and reset value
  localparam int CTRL_W = 4;
  localparam int CTRL_WIPER_WE = 0;  // wiper_write_enable_bit
  localparam int CTRL_NVM_PE   = 1;  // nvm_program_enable_bit
  localparam int CTRL_GAIN     = 2;  // gain_mode_select_bit
  localparam int CTRL_BURST    = 3;  // burst_enable_bit
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3;

  // Readback selectors in data bits 1:0
  localparam logic [1:0] READ_INPUT = 2'h0;
  localparam logic [1:0] READ_NVM   = 2'h1;
  localparam logic [1:0] READ_CTRL  = 2'h2;
  localparam logic [1:0] READ_WIPER = 2'h3;

endpackage

// [qpd_addr_ctrl.sv]
// Address decode, control register and tap decode of a quad potentiometer
//
// Overview of operation
// - Broadcast address bit set: command hits all four channels' input and wiper registers, not stored memory.
// - Top address bits zero: low two bits pick channel one to four.
// - Gain mode: resistor select bit picks A-to-wiper, else wiper-to-B.
// - Pot mode and stored memory: resistor select set has no target.
// - Write enable bit clear blocks input copy and top scale, and refuses serial wiper writes.
// - Write enable bit set allows serial wiper updates; resets to one.
// - Program enable bit gates every stored write; resets to one.
// - Gain mode select bit: zero potentiometer, one linear gain; resets zero.
// - Burst bit enables burst mode, resets zero, survives stop and restart.
// - Wiper code decodes to exactly one of 129 or 257 taps.
// - Pot mode: wiper-to-B rises with code, A-to-wiper is complementary.
// - Gain mode: A-to-wiper follows its own register, independent of B side.
// - Top scale selects a tap one step beyond full code.
// - Control command loads control bits from the four low data bits.
// - Burst: bytes after a command repeat it until the next start.
// - While protected, only stored-to-wiper copy and software reset may change a wiper.
`timescale 1ns/1ps

module qpd_addr_ctrl
  import qpd_pkg::*;
#(
  parameter int CODE_W = 8,                          // 7 or 8 bit variant
  parameter logic [CODE_W-1:0] NVM_INIT = 8'h80      // Stored value at reset
) (
  input  wire logic                        clk,         // 250 MHz clock
  input  wire logic                        reset,       // Sync, active high
  input  wire logic                        cmdValid,    // Command word strobe
  input  wire logic [15:0]                 cmdWord,     // Command word
  input  wire logic                        dataValid,   // Extra burst byte
  input  wire logic [7:0]                  dataByte,    // Burst data byte
  input  wire logic                        frameStart,  // Start or restart
  output logic                             readValid,   // Readback pulse
  output logic [7:0]                       readData,    // Readback value
  output logic [CTRL_W-1:0]                ctrlBits,    // Control register
  output logic [NUM_CH*(CODE_W+1)-1:0]     wbTap,       // Wiper-to-B taps
  output logic [NUM_CH*(CODE_W+1)-1:0]     awTap        // A-to-wiper steps
);

  localparam int TW = CODE_W + 1;
  localparam logic [TW-1:0] FULL_TAPS = {1'b1, {CODE_W{1'b0}}};

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [NUM_CH-1:0][CODE_W-1:0] inWb_q;     // Input registers, B side
  logic [NUM_CH-1:0][CODE_W-1:0] inAw_q;     // Input registers, A side
  logic [NUM_CH-1:0][CODE_W-1:0] wbWiper_q;  // Wiper registers, B side
  logic [NUM_CH-1:0][CODE_W-1:0] awWiper_q;  // Wiper registers, A side
  logic [NUM_CH-1:0][CODE_W-1:0] nvm_q;      // Stored wiper-to-B values
  logic [NUM_CH-1:0]             topScale_q; // Top scale per channel
  logic [CTRL_W-1:0]             ctrl_q;
  logic [7:0]                    heldCmd_q;  // Command and address byte
  logic                          burstActive_q;
  logic                          readValid_q;
  logic [7:0]                    readData_q;
  logic [NUM_CH-1:0][TW-1:0]     wbTap_q;
  logic [NUM_CH-1:0][TW-1:0]     awTap_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic [15:0]       execWord;
  logic              exec;
  logic [3:0]        opc;
  logic              bcast;
  logic              resSel;
  logic [1:0]        chSel;
  logic [7:0]        data;
  logic [CODE_W-1:0] code;
  logic              wiperWe;
  logic              nvmPe;
  logic              gainMode;
  logic [NUM_CH-1:0] wbHit;
  logic [NUM_CH-1:0] awHit;
  logic [NUM_CH-1:0] nvmHit;

  // Burst bytes reuse the held command byte
  assign exec     = cmdValid | (dataValid & burstActive_q);
  assign execWord = cmdValid ? cmdWord : {heldCmd_q, dataByte};
  assign opc      = execWord[OPC_MSB:OPC_LSB];
  assign bcast    = execWord[ADDR_BCAST_BIT];
  assign resSel   = execWord[ADDR_RES_BIT];
  assign chSel    = execWord[ADDR_CH_MSB:ADDR_CH_LSB];
  assign data     = execWord[7:0];
  assign code     = data[CODE_W-1:0];
  assign wiperWe  = ctrl_q[CTRL_WIPER_WE];
  assign nvmPe    = ctrl_q[CTRL_NVM_PE];
  assign gainMode = ctrl_q[CTRL_GAIN];

  // Per-channel targets from the address field
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      // Broadcast hits all, else channel number selects
      wbHit[i]  = exec & (bcast | (chSel == i[1:0] & ~resSel));
      // A side exists only in gain mode
      awHit[i]  = exec & gainMode
                & (bcast | (chSel == i[1:0] & resSel));
      // Stored memory: no broadcast, no A side
      nvmHit[i] = exec & ~bcast & ~resSel & (chSel == i[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input registers
  always_ff @(posedge clk) begin
    if (reset) begin
      inWb_q <= '0;
      inAw_q <= '0;
    end else if (opc == CMD_WR_INPUT) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wbHit[i]) inWb_q[i] <= code;
        if (awHit[i]) inAw_q[i] <= code;
      end
    end
  end

  // Wiper registers: reset loads B side with stored values, A side with zero
  always_ff @(posedge clk) begin
    if (reset) begin
      wbWiper_q  <= {NUM_CH{NVM_INIT}};
      awWiper_q  <= '0;
      topScale_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (opc == CMD_WR_WIPER && wiperWe) begin
          if (wbHit[i]) wbWiper_q[i] <= code;
          if (wbHit[i]) topScale_q[i] <= 1'b0;
          if (awHit[i]) awWiper_q[i] <= code;
        end else if (opc == CMD_COPY_IN && wiperWe) begin
          if (wbHit[i]) wbWiper_q[i] <= inWb_q[i];
          if (wbHit[i]) topScale_q[i] <= 1'b0;
          if (awHit[i]) awWiper_q[i] <= inAw_q[i];
        end else if (opc == CMD_SCALE && wiperWe && wbHit[i]
                     && data[SCALE_TOP_BIT]) begin
          topScale_q[i] <= data[0];
        end else if (opc == CMD_NVM_XFER && nvmHit[i]
                     && !data[XFER_DIR_BIT]) begin
          wbWiper_q[i]  <= nvm_q[i];
          topScale_q[i] <= 1'b0;
        end else if (opc == CMD_SW_RESET && exec) begin
          wbWiper_q[i]  <= nvm_q[i];
          topScale_q[i] <= 1'b0;
        end
      end
    end
  end

  // Stored values, gated by program enable
  always_ff @(posedge clk) begin
    if (reset) begin
      nvm_q <= {NUM_CH{NVM_INIT}};
    end else if (nvmPe) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (opc == CMD_WR_NVM && nvmHit[i]) nvm_q[i] <= code;
        if (opc == CMD_NVM_XFER && nvmHit[i] && data[XFER_DIR_BIT])
          nvm_q[i] <= wbWiper_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (exec && opc == CMD_CTRL) begin
      ctrl_q <= data[CTRL_W-1:0];
    end
  end

  // Burst tracking: a new start, or a command with the burst bit clear, ends it
  always_ff @(posedge clk) begin
    if (reset) begin
      heldCmd_q     <= 8'h00;
      burstActive_q <= 1'b0;
    end else if (cmdValid) begin
      heldCmd_q     <= cmdWord[15:8];
      burstActive_q <= ctrl_q[CTRL_BURST];
    end else if (frameStart) begin
      burstActive_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback
  always_ff @(posedge clk) begin
    if (reset) begin
      readValid_q <= 1'b0;
      readData_q  <= 8'h00;
    end else begin
      readValid_q <= exec && opc == CMD_READ;
      if (exec && opc == CMD_READ) begin
        readData_q <= 8'h00;
        case (data[1:0])
          READ_INPUT: readData_q[CODE_W-1:0] <=
                        (resSel && gainMode) ? inAw_q[chSel] : inWb_q[chSel];
          READ_NVM:   readData_q[CODE_W-1:0] <= nvm_q[chSel];
          READ_CTRL:  readData_q[CTRL_W-1:0] <= ctrl_q;
          default:    readData_q[CODE_W-1:0] <=
                        (resSel && gainMode) ? awWiper_q[chSel]
                                             : wbWiper_q[chSel];
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tap decode per channel
  always_ff @(posedge clk) begin
    if (reset) begin
      wbTap_q <= '0;
      awTap_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // One tap index per code, top scale one beyond
        wbTap_q[i] <= topScale_q[i] ? FULL_TAPS
                                    : {1'b0, wbWiper_q[i]};
        if (gainMode)
          awTap_q[i] <= {1'b0, awWiper_q[i]};
        else
          awTap_q[i] <= topScale_q[i] ? '0
                        : TW'(FULL_TAPS - {1'b0, wbWiper_q[i]});
      end
    end
  end

  // Outputs from flops
  assign readValid = readValid_q;
  assign readData  = readData_q;
  assign ctrlBits  = ctrl_q;
  assign wbTap     = wbTap_q;
  assign awTap     = awTap_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_bcast_all_wipers: assert property (
    @(posedge clk) disable iff (reset)
    exec && opc == CMD_WR_WIPER && bcast && wiperWe
    |=> wbWiper_q == {NUM_CH{$past(code)}})
    else $error("broadcast write missed a channel");

  a_chan_select: assert property (
    @(posedge clk) disable iff (reset)
    exec && opc == CMD_WR_INPUT && !bcast && !resSel
    |=> inWb_q[$past(chSel)] == $past(code))
    else $error("channel select wrote wrong input register");

  a_wiper_frozen: assert property (
    @(posedge clk) disable iff (reset)
    exec && !wiperWe && (opc == CMD_WR_WIPER || opc == CMD_COPY_IN)
    |=> $stable(wbWiper_q) && $stable(awWiper_q))
    else $error("protected wiper changed");

  a_nvm_gated: assert property (
    @(posedge clk) disable iff (reset)
    !nvmPe |=> $stable(nvm_q))
    else $error("stored value changed while disabled");

  a_ctrl_reset: assert property (
    @(posedge clk) reset |=> ctrl_q == CTRL_RESET)
    else $error("control register reset value wrong");

  a_ctrl_load: assert property (
    @(posedge clk) disable iff (reset)
    exec && opc == CMD_CTRL |=> ctrl_q == $past(data[CTRL_W-1:0]))
    else $error("control command not loaded");

  a_burst_holds: assert property (
    @(posedge clk) disable iff (reset)
    burstActive_q && !frameStart && !cmdValid |=> burstActive_q)
    else $error("burst ended without a start");

  a_no_target: assert property (
    @(posedge clk) disable iff (reset)
    exec && resSel && !bcast && !gainMode
    && (opc == CMD_WR_INPUT || opc == CMD_WR_NVM)
    |=> $stable(inWb_q) && $stable(inAw_q) && $stable(nvm_q))
    else $error("write without target changed a register");

  a_read_ctrl: assert property (
    @(posedge clk) disable iff (reset)
    exec && opc == CMD_READ && data[1:0] == READ_CTRL
    |=> readValid && readData == {4'h0, $past(ctrl_q)})
    else $error("control readback wrong");

  a_pot_complement: assert property (
    @(posedge clk) disable iff (reset)
    !reset && !gainMode && !topScale_q[0] ##1 !gainMode
    |-> TW'(wbTap_q[0] + awTap_q[0]) == FULL_TAPS)
    else $error("pot mode taps not complementary");

  a_burst_ctrl_kept: assert property (
    @(posedge clk) disable iff (reset)
    frameStart && !(exec && opc == CMD_CTRL)
    |=> $stable(ctrl_q))
    else $error("start changed the control register");

endmodule

// [qpd_host_model.sv]
// Host controller model driving the decoder's command port
`timescale 1ns/1ps

module qpd_host_model
  import qpd_pkg::*;
(
  input  wire logic        clk,        // Bench clock
  output logic             cmdValid,   // Command strobe
  output logic [15:0]      cmdWord,    // Command word
  output logic             dataValid,  // Burst byte strobe
  output logic [7:0]       dataByte,   // Burst byte
  output logic             frameStart  // Start or restart seen
);
  // Idle levels, set once while reset is held
  task automatic idle();
    cmdValid <= 1'b0;
    cmdWord <= 16'h0000;
    dataValid <= 1'b0;
    dataByte <= 8'h00;
    frameStart <= 1'b0;
  endtask

  // One command word; released word shows its inverse
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWord <= w;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdWord <= ~w;
  endtask

  // Extra data byte after a command
  task automatic burstByte(input logic [7:0] b);
    @(posedge clk);
    dataValid <= 1'b1;
    dataByte <= b;
    @(posedge clk);
    dataValid <= 1'b0;
    dataByte <= ~b;
  endtask

  // Repeated start on the serial bus
  task automatic restart();
    @(posedge clk);
    frameStart <= 1'b1;
    @(posedge clk);
    frameStart <= 1'b0;
  endtask

  // Control load with junk in the ignored fields
  task automatic loadCtrl(input logic [3:0] c);
    send({CMD_CTRL, 4'hA, 4'h5, c});
  endtask
endmodule

// [quad_pot_addr_decode_ctrl_tb_top.sv]
// Self-checking bench for the address decode and control block
`timescale 1ns/1ps

module quad_pot_addr_decode_ctrl_tb_top;
  import qpd_pkg::*;

  logic        clk = 1'b0;   // Bench clock
  logic        reset = 1'b1; // Sync reset
  logic        cmdValid;     // From host model
  logic [15:0] cmdWord;      // From host model
  logic        dataValid;    // From host model
  logic [7:0]  dataByte;     // From host model
  logic        frameStart;   // From host model
  logic        readValid;    // Readback pulse
  logic [7:0]  readData;     // Readback value
  logic [3:0]  ctrlBits;     // Control register
  logic [35:0] wbTap;        // Wiper-to-B taps
  logic [35:0] awTap;        // A-to-wiper steps
  int          fails = 0;
  int          check_count = 0;
  logic [15:0] rdCmd [4] = '{16'h3002, 16'h3003, 16'h3001, 16'h3000};
  logic [7:0]  rdExp [4] = '{8'h03, 8'h55, 8'h80, 8'h00};
  logic [7:0]  rv;

  // Clock at 4 ns period
  always #2 clk = ~clk;

  qpd_host_model host (.clk(clk), .cmdValid(cmdValid), .cmdWord(cmdWord),
    .dataValid(dataValid), .dataByte(dataByte), .frameStart(frameStart));

  qpd_addr_ctrl #(.CODE_W(8), .NVM_INIT(8'h80)) uut (.clk(clk),
    .reset(reset), .cmdValid(cmdValid), .cmdWord(cmdWord),
    .dataValid(dataValid), .dataByte(dataByte), .frameStart(frameStart),
    .readValid(readValid), .readData(readData), .ctrlBits(ctrlBits),
    .wbTap(wbTap), .awTap(awTap));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare and report
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Let taps catch up with a wiper change
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Readback command, bounded wait for the pulse
  task automatic rd(input logic [15:0] w, output logic [7:0] d);
    host.send(w);
    #1;
    for (int i = 0; i < 4 && readValid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("readValid", 9'h001, {8'h00, readValid});
    d = readData;
  endtask

  function automatic logic [8:0] wb(int c);
    return wbTap[c*9 +: 9];
  endfunction

  function automatic logic [8:0] aw(int c);
    return awTap[c*9 +: 9];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #(4 * 3000);
    fails++;
    end_sim();
  end

  // Main sequence
  initial begin
    host.idle();
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk("ctrlBits", 9'h003, {5'h00, ctrlBits});
    chk("wbTap0", 9'h080, wb(0));
    chk("awTap0", 9'h080, aw(0));
    host.send(16'h1240);
    settle();
    chk("wbTap2", 9'h040, wb(2));
    chk("awTap2", 9'h0C0, aw(2));
    host.send(16'h1855);
    settle();
    for (int c = 0; c < 4; c++) chk("wbTapAll", 9'h055, wb(c));
    host.send(16'h1433);
    host.send(16'h2433);
    settle();
    chk("wbTap0", 9'h055, wb(0));
    rd(16'h3000, rv);
    chk("input0", 9'h000, {1'b0, rv});
    host.send(16'h9181);
    settle();
    chk("wbTap1", 9'h100, wb(1));
    chk("awTap1", 9'h000, aw(1));
    for (int i = 0; i < 4; i++) begin
      rd(rdCmd[i], rv);
      chk("readData", {1'b0, rdExp[i]}, {1'b0, rv});
    end
    host.loadCtrl(4'h0);
    settle();
    chk("ctrlBits", 9'h000, {5'h00, ctrlBits});
    host.send(16'h1010);
    host.send(16'h6100);
    settle();
    chk("wbTap0", 9'h055, wb(0));
    chk("wbTap1", 9'h100, wb(1));
    host.send(16'h8022);
    rd(16'h3001, rv);
    chk("stored0", 9'h080, {1'b0, rv});
    host.send(16'h7000);
    settle();
    chk("wbTap0", 9'h080, wb(0));
    host.loadCtrl(4'h7);
    host.send(16'h1730);
    settle();
    chk("awTap3", 9'h030, aw(3));
    chk("wbTap3", 9'h055, wb(3));
    host.send(16'h1321);
    settle();
    chk("wbTap3", 9'h021, wb(3));
    chk("awTap3", 9'h030, aw(3));
    host.send(16'h2177);
    host.send(16'h6100);
    host.send(16'h7101);
    host.send(16'h8233);
    settle();
    chk("wbTap1", 9'h077, wb(1));
    rd(16'h3101, rv);
    chk("stored1", 9'h077, {1'b0, rv});
    host.send(16'hB000);
    settle();
    chk("wbTap2", 9'h033, wb(2));
    chk("wbTap3", 9'h080, wb(3));
    host.send(16'h1844);
    settle();
    chk("awTap0", 9'h044, aw(0));
    chk("wbTap3", 9'h044, wb(3));
    host.loadCtrl(4'hF);
    host.send(16'h2000);
    host.burstByte(8'h11);
    host.restart();
    host.burstByte(8'h22);
    settle();
    chk("ctrlBits", 9'h00F, {5'h00, ctrlBits});
    rd(16'h3000, rv);
    chk("input0", 9'h011, {1'b0, rv});
    // Second reset in mid-run reloads defaults
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk("ctrlBits", 9'h003, {5'h00, ctrlBits});
    chk("wbTap3", 9'h080, wb(3));
    chk("awTap3", 9'h080, aw(3));
    end_sim();
  end
endmodule
